// >>> pkg/gdfc_pkg.sv
package gdfc_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25; // core clock rate
	localparam int CAL_TIME_US = 500; // longest calibration time
	localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ; // cycles, exact product
	localparam int RETRY_TIME_MS = 4; // automatic retry period
	localparam int RETRY_CYCLES = RETRY_TIME_MS * 1000 * CLK_MHZ; // cycles
	localparam int OCP_DEG_NS = 4500; // overcurrent deglitch time
	localparam int OCP_DEG_CYCLES = (OCP_DEG_NS * CLK_MHZ + 999) / 1000; // rounded up
	localparam int CNT_W = 17; // width of the shared timers
	localparam int DEG_W = 8; // width of deglitch counters
	localparam int N_FET = 6; // monitored transistors

	// ----------------------------------------
	// overcurrent action encodings
	// ----------------------------------------
	localparam logic [1:0] OCP_LATCH = 2'h0; // latched shutdown
	localparam logic [1:0] OCP_RETRY = 2'h1; // automatic retry
	localparam logic [1:0] OCP_REPORT = 2'h2; // report only
	localparam logic [1:0] OCP_OFF = 2'h3; // disabled

	// ----------------------------------------
	// calibration sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		GDFC_CAL_WAIT = 2'b00, // waiting for reference to be valid
		GDFC_CAL_RUN = 2'b01, // inputs shorted, calibrating
		GDFC_CAL_IDLE = 2'b10 // normal sensing
	} gdfc_cal_t;

endpackage : gdfc_pkg

// >>> rtl/gdfc_deglitch.sv
`timescale 1ns/100ps
// flags a level only after it stays high for a number of cycles
module gdfc_deglitch
	import gdfc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// condition
	input wire logic raw,
	output logic qual
);

	logic [DEG_W-1:0] cnt_q; // high-time counter

	// count while high, restart on any low; a glitch never qualifies
	always_ff @(posedge clk) begin
		if (rst || !raw) begin
			cnt_q <= '0;
			qual <= 1'b0;
		end else if (cnt_q >= DEG_W'(OCP_DEG_CYCLES)) begin
			qual <= 1'b1;
		end else begin
			cnt_q <= cnt_q + DEG_W'(1);
		end
	end

endmodule : gdfc_deglitch

// >>> rtl/gdfc_top.sv
`timescale 1ns/100ps
module gdfc_top
	import gdfc_pkg::*;
(
	// clock and reset (reset also from enable reset pulse)
	input wire logic clk,
	input wire logic rst,
	// analog monitor levels (asynchronous)
	input wire logic supply_low_raw,
	input wire logic pump_low_raw,
	input wire logic vref_ok_raw,
	input wire logic gate_stuck_raw,
	input wire logic [N_FET-1:0] drain_over_raw,
	input wire logic [N_FET-1:0] fet_on,
	input wire logic cal_pin,
	// configuration bits
	input wire logic vref_div_bypass,
	input wire logic auto_offset_cal,
	input wire logic manual_cal,
	input wire logic pump_undervolt_disable,
	input wire logic gate_fault_disable,
	input wire logic [1:0] overcurrent_action_select,
	input wire logic fault_clear_bit,
	// gate and analog control
	output logic gates_hiz,
	output logic pump_enable,
	output logic logic_enable,
	output logic amp_unidir,
	output logic amp_inputs_shorted,
	output logic cal_busy,
	// fault output, open drain
	output logic fault_out_low_o,
	output logic fault_out_low_oe,
	// status flags
	output logic fault_flag,
	output logic supply_undervolt_flag,
	output logic pump_undervolt_flag,
	output logic drain_overcurrent,
	output logic [N_FET-1:0] fet_overcurrent,
	output logic gate_drive_fault
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int N_SYNC = 5 + N_FET;
	logic [N_SYNC-1:0] sync1_q; // first stage, read only by stage two
	logic [N_SYNC-1:0] sync2_q; // safe to use
	logic uv_s, cp_s, vref_s, gs_s, calp_s;
	logic [N_FET-1:0] ds_s;

	// two stages for every monitor level except fet_on
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {drain_over_raw, cal_pin, gate_stuck_raw, vref_ok_raw, pump_low_raw, supply_low_raw};
			sync2_q <= sync1_q;
		end
	end
	assign {ds_s, calp_s, gs_s, vref_s, cp_s, uv_s} = sync2_q;

	// ----------------------------------------
	// overcurrent deglitch, per transistor
	// ----------------------------------------
	logic [N_FET-1:0] ds_qual;
	genvar gi;
	generate
		for (gi = 0; gi < N_FET; gi++) begin : g_deg
			// only a conducting transistor can trip
			gdfc_deglitch u_deg (
				.clk(clk),
				.rst(rst),
				.raw(ds_s[gi] && fet_on[gi]),
				.qual(ds_qual[gi])
			);
		end
	endgenerate
	logic oc_now;
	assign oc_now = |ds_qual;

	// ----------------------------------------
	// calibration sequencer
	// ----------------------------------------
	gdfc_cal_t cal_q;
	logic [CNT_W-1:0] cal_cnt_q;
	logic auto_offset_cal_prev_q; // for edge detect on the request bit

	always_ff @(posedge clk) begin
		if (rst) begin
			auto_offset_cal_prev_q <= 1'b0;
		end else begin
			auto_offset_cal_prev_q <= auto_offset_cal;
		end
	end

	// reset covers power-up and enable pulse; start once reference is valid
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_q <= GDFC_CAL_WAIT;
			cal_cnt_q <= '0;
		end else begin
			case (cal_q)
				GDFC_CAL_WAIT: begin
					cal_cnt_q <= '0;
					if (vref_s) begin
						cal_q <= GDFC_CAL_RUN;
					end
				end
				GDFC_CAL_RUN: begin
					// fixed length: the longest allowed time, so a write after it is safe
					if (cal_cnt_q == CNT_W'(CAL_CYCLES - 1)) begin
						cal_q <= GDFC_CAL_IDLE;
					end else begin
						cal_cnt_q <= cal_cnt_q + CNT_W'(1);
					end
				end
				GDFC_CAL_IDLE: begin
					cal_cnt_q <= '0;
					// a held bit does nothing; it must go low and high again
					if (auto_offset_cal && !auto_offset_cal_prev_q) begin
						cal_q <= GDFC_CAL_RUN;
					end
				end
				default: cal_q <= GDFC_CAL_WAIT;
			endcase
		end
	end

	assign cal_busy = (cal_q != GDFC_CAL_IDLE);
	assign amp_inputs_shorted = cal_busy || manual_cal || calp_s;
	assign amp_unidir = vref_div_bypass;

	// ----------------------------------------
	// undervoltage and gate fault flags
	// ----------------------------------------
	logic cp_act;
	logic gdf_act;
	assign cp_act = cp_s && !pump_undervolt_disable;
	assign gdf_act = gs_s && !gate_fault_disable;

	// sticky flags; a new event in the clear cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			supply_undervolt_flag <= 1'b0;
			pump_undervolt_flag <= 1'b0;
			gate_drive_fault <= 1'b0;
		end else begin
			supply_undervolt_flag <= uv_s || (supply_undervolt_flag && !fault_clear_bit);
			pump_undervolt_flag <= cp_act || (pump_undervolt_flag && !fault_clear_bit);
			gate_drive_fault <= gdf_act || (gate_drive_fault && !fault_clear_bit);
		end
	end

	// ----------------------------------------
	// overcurrent handling by action mode
	// ----------------------------------------
	logic [CNT_W-1:0] retry_cnt_q; // retry period timer
	logic retry_run_q;
	logic oc_report;
	logic [N_FET-1:0] oc_set;
	logic oc_clear;
	assign oc_report = (overcurrent_action_select != OCP_OFF);
	assign oc_set = oc_report ? ds_qual : '0;
	// retry mode clears only at expiry; others by clear command once removed
	assign oc_clear = (overcurrent_action_select == OCP_RETRY)
		? (retry_run_q && retry_cnt_q == CNT_W'(RETRY_CYCLES - 1))
		: (fault_clear_bit && !oc_now);

	// per-transistor latched flags
	always_ff @(posedge clk) begin
		if (rst) begin
			fet_overcurrent <= '0;
		end else if (oc_clear) begin
			fet_overcurrent <= oc_set;
		end else begin
			fet_overcurrent <= fet_overcurrent | oc_set;
		end
	end
	assign drain_overcurrent = |fet_overcurrent;

	// retry timer runs from the event for one full period
	always_ff @(posedge clk) begin
		if (rst || overcurrent_action_select != OCP_RETRY) begin
			retry_run_q <= 1'b0;
			retry_cnt_q <= '0;
		end else if (!retry_run_q) begin
			retry_run_q <= oc_now;
			retry_cnt_q <= '0;
		end else if (retry_cnt_q == CNT_W'(RETRY_CYCLES - 1)) begin
			retry_run_q <= 1'b0;
			retry_cnt_q <= '0;
		end else begin
			retry_cnt_q <= retry_cnt_q + CNT_W'(1);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	logic oc_shut;
	assign oc_shut = drain_overcurrent && (overcurrent_action_select == OCP_LATCH
		|| overcurrent_action_select == OCP_RETRY);
	assign gates_hiz = uv_s || cp_act || oc_shut || gate_drive_fault;
	assign pump_enable = !uv_s;
	assign logic_enable = !uv_s;
	assign fault_flag = supply_undervolt_flag || pump_undervolt_flag
		|| drain_overcurrent || gate_drive_fault;
	// supply and pump flags stay, but the pin releases once the condition ends
	assign fault_out_low_oe = uv_s || cp_act
		|| drain_overcurrent || gate_drive_fault;
	assign fault_out_low_o = 1'b0; // open drain: only ever pulls low

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_uv_tristate: assert property (@(posedge clk) disable iff (rst) uv_s |-> gates_hiz && !pump_enable && fault_out_low_oe)
		else $error("undervoltage did not shut down");
	a_uv_flag_held: assert property (@(posedge clk) disable iff (rst)
		supply_undervolt_flag && !fault_clear_bit |=> supply_undervolt_flag)
		else $error("supply flag lost without clear");
	a_cp_disable: assert property (@(posedge clk) disable iff (rst)
		pump_undervolt_disable && !pump_undervolt_flag |=> !pump_undervolt_flag)
		else $error("pump flag set while disabled");
	a_cp_report: assert property (@(posedge clk) disable iff (rst) cp_act |-> gates_hiz && fault_out_low_oe)
		else $error("pump undervoltage not acted on");
	a_oc_off_mode: assert property (@(posedge clk) disable iff (rst)
		overcurrent_action_select == OCP_OFF && fet_overcurrent == '0 |=> fet_overcurrent == '0)
		else $error("overcurrent flagged in disabled mode");
	a_oc_report_gate: assert property (@(posedge clk) disable iff (rst)
		overcurrent_action_select == OCP_REPORT && !uv_s && !cp_act && !gate_drive_fault |-> !gates_hiz)
		else $error("report mode tristated gates");
	a_oc_latch_hold: assert property (@(posedge clk) disable iff (rst)
		overcurrent_action_select == OCP_LATCH && $past(overcurrent_action_select) == OCP_LATCH
		&& $past(drain_overcurrent) && !$past(fault_clear_bit) |-> drain_overcurrent && gates_hiz)
		else $error("latched shutdown released early");
	a_gdf_latch: assert property (@(posedge clk) disable iff (rst)
		gdf_act |=> gate_drive_fault && gates_hiz)
		else $error("gate fault not latched");
	a_auto_offset_cal_edge: assert property (@(posedge clk) disable iff (rst)
		cal_q == GDFC_CAL_IDLE && !(auto_offset_cal && !auto_offset_cal_prev_q) |=> cal_q == GDFC_CAL_IDLE)
		else $error("calibration without rising request");
	a_cal_short: assert property (@(posedge clk) disable iff (rst) cal_q == GDFC_CAL_RUN |-> amp_inputs_shorted)
		else $error("inputs open during calibration");

endmodule : gdfc_top

// >>> sim/gdfc_mcu_model.sv
`timescale 1ns/100ps
// controller side of the fault line, board pull-up included
module gdfc_mcu_model (
	// open-drain pin from the device
	input wire logic fault_out_low_o,
	input wire logic fault_out_low_oe,
	// level the controller reads
	output logic fault_pin_n
);
	// a released pin floats up, never keeps the last level
	assign fault_pin_n = fault_out_low_oe ? fault_out_low_o : 1'h1;
endmodule : gdfc_mcu_model

// >>> sim/test_gdfc_top.sv
`timescale 1ns/100ps
module test_gdfc_top
	import gdfc_pkg::*;
;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic supply_low_raw = 1'h0, pump_low_raw = 1'h0, vref_ok_raw = 1'h0, gate_stuck_raw = 1'h0;
	logic cal_pin = 1'h0, vref_div_bypass = 1'h0, auto_offset_cal = 1'h0, manual_cal = 1'h0;
	logic pump_undervolt_disable = 1'h0, gate_fault_disable = 1'h0, fault_clear_bit = 1'h0;
	logic [N_FET-1:0] drain_over_raw = '0, fet_on = '0, fet_overcurrent;
	logic [1:0] overcurrent_action_select = 2'h0;
	logic gates_hiz, pump_enable, logic_enable, amp_unidir, amp_inputs_shorted, cal_busy;
	logic fault_out_low_o, fault_out_low_oe, fault_flag, supply_undervolt_flag;
	logic pump_undervolt_flag, drain_overcurrent, gate_drive_fault, fault_pin_n;
	int err_count = 0, total_checks = 0;
	// rows: monitor and config inputs, then {hiz, pin, pump, unidir, shorted}
	logic [12:0] rows [9] = '{13'h1010, 13'h0814, 13'h0C0C, 13'h0214, 13'h030C,
		13'h008E, 13'h004D, 13'h002D, 13'h000C};

	gdfc_top dut (.clk, .rst, .supply_low_raw, .pump_low_raw, .vref_ok_raw, .gate_stuck_raw,
		.drain_over_raw, .fet_on, .cal_pin, .vref_div_bypass, .auto_offset_cal, .manual_cal,
		.pump_undervolt_disable, .gate_fault_disable, .overcurrent_action_select, .fault_clear_bit,
		.gates_hiz, .pump_enable, .logic_enable, .amp_unidir, .amp_inputs_shorted, .cal_busy,
		.fault_out_low_o, .fault_out_low_oe, .fault_flag, .supply_undervolt_flag,
		.pump_undervolt_flag, .drain_overcurrent, .fet_overcurrent, .gate_drive_fault);
	gdfc_mcu_model mcu (.fault_out_low_o, .fault_out_low_oe, .fault_pin_n);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		forever #20 clk = ~clk;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// sample 1 ns after the edge so outputs have settled, then realign to the edge
	task chk(input logic [7:0] got, input logic [7:0] exp);
		#1;
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
		@(posedge clk);
	endtask : chk
	task put(input logic [7:0] v);
		{supply_low_raw, pump_low_raw, pump_undervolt_disable, gate_stuck_raw, gate_fault_disable,
			vref_div_bypass, manual_cal, cal_pin} <= v;
	endtask : put
	// clear held for several cycles, as a controller write would leave it
	task clr();
		fault_clear_bit <= 1'h1;
		cyc(3);
		fault_clear_bit <= 1'h0;
		cyc(3);
	endtask : clr
	task oc(input logic [5:0] f, input int n);
		drain_over_raw <= 6'h01;
		fet_on <= f;
		cyc(n);
		drain_over_raw <= 6'h00;
		cyc(4);
	endtask : oc
	task close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// runs take about 40k cycles
	initial begin
		#2400000;
		err_count++;
		close_out();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cyc(2);
		rst <= 1'h0;
		cyc(10);
		chk({fault_flag, cal_busy, amp_inputs_shorted}, 8'h03);
		cyc(1);
		vref_ok_raw <= 1'h1;
		cyc(12400);
		chk({cal_busy, amp_inputs_shorted}, 8'h03);
		cyc(120);
		chk({cal_busy, amp_inputs_shorted}, 8'h00);
		for (int i = 0; i < 9; i++) begin
			cyc(1);
			put(rows[i][12:5]);
			cyc(5);
			chk({gates_hiz, fault_pin_n, pump_enable, amp_unidir, amp_inputs_shorted}, rows[i][4:0]);
			cyc(1);
			put(8'h00);
			cyc(4);
			clr();
		end
		// flags outlive the condition until cleared
		put(8'hC0);
		cyc(5);
		chk({logic_enable, pump_enable, gates_hiz, fault_pin_n, fault_flag}, 8'h05);
		put(8'h00);
		cyc(5);
		chk({fault_pin_n, gates_hiz, supply_undervolt_flag, pump_undervolt_flag}, 8'h0B);
		clr();
		chk({supply_undervolt_flag, pump_undervolt_flag, fault_flag}, 8'h00);
		// run-time calibration wants a fresh rising bit
		auto_offset_cal <= 1'h1;
		cyc(4);
		chk({cal_busy, amp_inputs_shorted}, 8'h03);
		cyc(12600);
		chk(cal_busy, 8'h00);
		auto_offset_cal <= 1'h0;
		cyc(4);
		auto_offset_cal <= 1'h1;
		cyc(4);
		chk(cal_busy, 8'h01);
		cyc(12600);
		auto_offset_cal <= 1'h0;
		// short spikes and idle transistors never trip
		oc(6'h01, 100);
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h04);
		oc(6'h00, 200);
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h04);
		oc(6'h01, 150);
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h0B);
		clr();
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h04);
		overcurrent_action_select <= OCP_RETRY;
		oc(6'h01, 150);
		cyc(1000);
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h0B);
		// short reset pulse clears everything and recalibrates
		rst <= 1'h1;
		cyc(1);
		rst <= 1'h0;
		cyc(4);
		chk({cal_busy, gates_hiz, fault_pin_n, drain_overcurrent}, 8'h0A);
		overcurrent_action_select <= OCP_REPORT;
		oc(6'h01, 150);
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h03);
		clr();
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h04);
		overcurrent_action_select <= OCP_OFF;
		oc(6'h01, 150);
		chk({gates_hiz, fault_pin_n, drain_overcurrent, fet_overcurrent[0]}, 8'h04);
		close_out();
	end
endmodule : test_gdfc_top
